// ### inc/dpm_pkg.sv
// Types shared by the display pin multiplexer modules.
package dpm_pkg;

  typedef enum logic [0:0] {
    APB_IDLE,
    APB_DONE
  } dpm_apb_t;

  typedef struct packed {
    logic [1:0] scan;
    logic [3:0] fmt;
    logic twin;
    logic [23:0] doe;
    logic pclk_out_en;
    logic dac_oe;
    logic gate_en;
    logic [3:0] div;
    logic [4:0] dly_sel;
    dpm_apb_t apb;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [23:0] pix;
    logic [23:0] dis_d;
    logic [23:0] dis_oe;
    logic [4:0] dly_use;
    logic [7:0] ana_r;
    logic [7:0] ana_g;
    logic [7:0] ana_b;
    logic ana_oe;
    logic [3:0] div_cnt;
    logic pclk;
    logic pclk_oe;
  } dpm_top_state_t;

endpackage

// ### inc/dpm_regs.svh
// Register offsets, field positions, reset values and codes of the display pin multiplexer.
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH

`define DPM_ADDR_CFG 12'h000
`define DPM_ADDR_DOE 12'h004
`define DPM_ADDR_CTRL 12'h008
`define DPM_ADDR_STAT 12'h00C

`define DPM_CFG_SCAN_LSB 0
`define DPM_CFG_FMT_LSB 4
`define DPM_CFG_TWIN_BIT 8
`define DPM_CTRL_PCLK_OUT_BIT 0
`define DPM_CTRL_DAC_OE_BIT 1
`define DPM_CTRL_GATE_BIT 2
`define DPM_CTRL_DIV_LSB 4
`define DPM_CTRL_DLY_LSB 8

`define DPM_RST_SCAN 2'h0
`define DPM_RST_FMT 4'h8
`define DPM_RST_DOE 24'h00_0000
`define DPM_RST_DIV 4'h0
`define DPM_RST_DLY 5'h00

`define DPM_SCAN_SINGLE 2'h0
`define DPM_SCAN_ILLEGAL 2'h1
`define DPM_SCAN_DUAL 2'h2
`define DPM_SCAN_ZIGZAG 2'h3

`define DPM_FMT_9BIT 4'h5
`define DPM_FMT_24BIT 4'h8
`define DPM_FMT_ANALOG 4'h9
`define DPM_FMT_RSVD_MIN 4'hA

`define DPM_FIFO_DEPTH 4
`define DPM_PIX_W 24

`endif

// ### rtl/dpm_fifo.sv
// Small synchronous FIFO holding pixel words ahead of the pin multiplexer.
`timescale 1ns/1ns
module dpm_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side.
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side.
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } dpm_fifo_state_t;

  dpm_fifo_state_t s_q;
  dpm_fifo_state_t s_d;
  logic push;
  logic pop;

  assign in_ready_o = (s_q.cnt != (AW + 1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = s_q.mem[s_q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointers wrap at DEPTH, so any depth works, not only powers of two.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_i;
      s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    if (rst_i) begin
      s_d.wr = '0;
      s_d.rd = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

endmodule

// ### rtl/dpm_half_delay.sv
// Per-bit optional half-clock delay for the sync outputs on the top data pins.
`timescale 1ns/1ns
module dpm_half_delay #(
  parameter int WIDTH = 5
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Registered signal and per-bit delay select.
  input wire logic [WIDTH-1:0] sig_i,
  input wire logic [WIDTH-1:0] sel_i,
  output logic [WIDTH-1:0] sig_o
);

  typedef struct packed {
    logic [WIDTH-1:0] neg;
  } dpm_dly_state_t;

  dpm_dly_state_t s_q;
  dpm_dly_state_t s_d;

  always_comb begin
    s_d.neg = rst_i ? '0 : sig_i;
  end

  // The falling edge copy lags the rising edge register by half a cycle.
  always_ff @(negedge clk_i) begin
    s_q <= s_d;
  end

  // Each bit picks its own source, so delays are set per output.
  assign sig_o = (sel_i & s_q.neg) | (~sel_i & sig_i);

endmodule

// ### rtl/dpm_top.sv
// Display connector pin multiplexer with APB configuration registers.
//
// How it works
// [RL1] Single scan: pins 23..19 carry pixel data for 24-bit, or analog with twin.
// [RL2] Dual scan: lower segment on pins 15..8, upper segment on pins 7..0.
// [RL3] Dual scan: pins 18..16 are zero, pins 23..19 carry syncs 7..3, each delayed only if selected.
// [RL4] Zigzag: pins 23..19 syncs, 18..8 zero, 7..0 pixel data.
// [RL5] Sync outputs 3..7 have no other pin path when top pins carry data.
// [RL6] Each pin's output enable is applied after the signal selection.
// [RL7] Pixel clock pin, when an output, carries the gated and divided clock.
// [RL8] Analog pins drive for single scan analog, or twin with 9..24-bit formats.
// [RL9] Analog pins float whenever the converter output enable is cleared.
// [RL10] Scan field: 0 single, 2 dual, 3 zigzag, 1 illegal.
// [RL11] Format field: 5 is 9-bit, 8 is 24-bit, 9 analog, 10..15 reserved.
// [RL12] Sync generator 3 goes to pin 19, up to generator 7 on pin 23.
// [RL13] Each sync output can be delayed half a clock, individually selected.
// [RL14] Selection uses registered configuration and changes on the next clock.
`timescale 1ns/1ns
`include "dpm_regs.svh"
module dpm_top (
  // Clock and reset.
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [31:0] PRDATA_O,
  // Pixel stream in.
  input wire logic PIX_VALID_I,
  input wire logic [23:0] PIX_DATA_I,
  output logic PIX_READY_O,
  input wire logic PIX_STALL_I,
  // Sync generator outputs and analog colour codes.
  input wire logic [7:0] SYNC_MIX_I,
  input wire logic [7:0] ANA_R_I,
  input wire logic [7:0] ANA_G_I,
  input wire logic [7:0] ANA_B_I,
  // Display connector pins.
  output logic [23:0] DIS_D_O,
  output logic [23:0] DIS_D_OE_O,
  output logic DIS_PCLK_O,
  output logic DIS_PCLK_OE_O,
  output logic [7:0] ANA_R_O,
  output logic [7:0] ANA_G_O,
  output logic [7:0] ANA_B_O,
  output logic ANA_OE_O
);

  dpm_pkg::dpm_top_state_t s_q;
  dpm_pkg::dpm_top_state_t s_d;
  logic fifo_valid;
  logic [23:0] fifo_data;
  logic fifo_pop;
  logic fifo_ready;
  logic [4:0] top_dly;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // True when pins 23..19 do not carry pixel data; they carry syncs, or zero for the illegal scan code.
  function automatic logic sync_on_top(input logic [1:0] scan, input logic [3:0] fmt,
                                       input logic twin);
    logic data_top;
    data_top = (scan == `DPM_SCAN_SINGLE) &&
               ((fmt == `DPM_FMT_24BIT) || ((fmt == `DPM_FMT_ANALOG) && twin)); // [RL1]
    return !data_top;
  endfunction

  // True when the analog colour pins should carry converter values.
  function automatic logic analog_on(input logic [1:0] scan, input logic [3:0] fmt,
                                     input logic twin);
    logic prim;
    logic sec;
    prim = (scan == `DPM_SCAN_SINGLE) && (fmt == `DPM_FMT_ANALOG);
    sec = twin && (fmt >= `DPM_FMT_9BIT) && (fmt <= `DPM_FMT_24BIT); // [RL8] [RL11]
    return prim || sec;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel buffer.

  assign fifo_pop = fifo_valid && !PIX_STALL_I;

  dpm_fifo #(
    .WIDTH(`DPM_PIX_W),
    .DEPTH(`DPM_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(PIX_VALID_I),
    .in_data_i(PIX_DATA_I),
    .in_ready_o(fifo_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(!PIX_STALL_I)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_d = s_q;
    // APB: the answer comes one cycle into the access phase.
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.apb = dpm_pkg::APB_IDLE;
    case (s_q.apb)
      dpm_pkg::APB_IDLE: begin
        if (PSEL_I && PENABLE_I) begin
          s_d.apb = dpm_pkg::APB_DONE;
          s_d.pready = 1'b1;
          s_d.prdata = '0;
          case (PADDR_I)
            `DPM_ADDR_CFG: begin
              if (PWRITE_I) begin
                s_d.scan = PWDATA_I[`DPM_CFG_SCAN_LSB +: 2];
                s_d.fmt = PWDATA_I[`DPM_CFG_FMT_LSB +: 4];
                s_d.twin = PWDATA_I[`DPM_CFG_TWIN_BIT];
              end
              s_d.prdata[`DPM_CFG_SCAN_LSB +: 2] = s_q.scan;
              s_d.prdata[`DPM_CFG_FMT_LSB +: 4] = s_q.fmt;
              s_d.prdata[`DPM_CFG_TWIN_BIT] = s_q.twin;
            end
            `DPM_ADDR_DOE: begin
              if (PWRITE_I) begin
                s_d.doe = PWDATA_I[23:0];
              end
              s_d.prdata[23:0] = s_q.doe;
            end
            `DPM_ADDR_CTRL: begin
              if (PWRITE_I) begin
                s_d.pclk_out_en = PWDATA_I[`DPM_CTRL_PCLK_OUT_BIT];
                s_d.dac_oe = PWDATA_I[`DPM_CTRL_DAC_OE_BIT];
                s_d.gate_en = PWDATA_I[`DPM_CTRL_GATE_BIT];
                s_d.div = PWDATA_I[`DPM_CTRL_DIV_LSB +: 4];
                s_d.dly_sel = PWDATA_I[`DPM_CTRL_DLY_LSB +: 5];
              end
              s_d.prdata[`DPM_CTRL_PCLK_OUT_BIT] = s_q.pclk_out_en;
              s_d.prdata[`DPM_CTRL_DAC_OE_BIT] = s_q.dac_oe;
              s_d.prdata[`DPM_CTRL_GATE_BIT] = s_q.gate_en;
              s_d.prdata[`DPM_CTRL_DIV_LSB +: 4] = s_q.div;
              s_d.prdata[`DPM_CTRL_DLY_LSB +: 5] = s_q.dly_sel;
            end
            `DPM_ADDR_STAT: begin
              s_d.pslverr = PWRITE_I;
              s_d.prdata[0] = sync_on_top(s_q.scan, s_q.fmt, s_q.twin);
              s_d.prdata[1] = analog_on(s_q.scan, s_q.fmt, s_q.twin);
              s_d.prdata[2] = (s_q.scan == `DPM_SCAN_ILLEGAL); // [RL10]
              s_d.prdata[3] = (s_q.fmt >= `DPM_FMT_RSVD_MIN); // [RL11]
              s_d.prdata[4] = fifo_valid;
              s_d.prdata[5] = fifo_ready;
            end
            default: begin
              s_d.pslverr = 1'b1;
            end
          endcase
        end
      end
      dpm_pkg::APB_DONE: begin
        s_d.apb = dpm_pkg::APB_IDLE;
      end
      default: begin
        s_d.apb = dpm_pkg::APB_IDLE;
      end
    endcase

    if (fifo_pop) begin
      s_d.pix = fifo_data;
    end

    // Pin selection from registered configuration only. [RL14]
    s_d.dly_use = '0;
    case (s_q.scan)
      `DPM_SCAN_SINGLE: begin
        s_d.dis_d[18:0] = s_q.pix[18:0]; // [RL1]
        if (sync_on_top(s_q.scan, s_q.fmt, s_q.twin)) begin
          s_d.dis_d[23:19] = SYNC_MIX_I[7:3]; // [RL1] [RL12]
          s_d.dly_use = s_q.dly_sel; // [RL13]
        end else begin
          s_d.dis_d[23:19] = s_q.pix[23:19]; // [RL5]
        end
      end
      `DPM_SCAN_DUAL: begin
        s_d.dis_d[15:0] = s_q.pix[15:0]; // [RL2]
        s_d.dis_d[18:16] = 3'h0; // [RL3]
        s_d.dis_d[23:19] = SYNC_MIX_I[7:3]; // [RL3] [RL12]
        s_d.dly_use = s_q.dly_sel; // [RL13]
      end
      `DPM_SCAN_ZIGZAG: begin
        s_d.dis_d[7:0] = s_q.pix[7:0]; // [RL4]
        s_d.dis_d[18:8] = 11'h000; // [RL4]
        s_d.dis_d[23:19] = SYNC_MIX_I[7:3]; // [RL4] [RL12]
        s_d.dly_use = s_q.dly_sel; // [RL13]
      end
      default: begin
        s_d.dis_d = '0;
      end
    endcase
    // Enables act after selection; an illegal scan code drives no data pin. [RL6] [RL10]
    s_d.dis_oe = (s_q.scan == `DPM_SCAN_ILLEGAL) ? '0 : s_q.doe;

    // Analog pins float unless the mode wants them and the converter is enabled.
    s_d.ana_oe = s_q.dac_oe && analog_on(s_q.scan, s_q.fmt, s_q.twin); // [RL8] [RL9]
    s_d.ana_r = s_d.ana_oe ? ANA_R_I : 8'h00;
    s_d.ana_g = s_d.ana_oe ? ANA_G_I : 8'h00;
    s_d.ana_b = s_d.ana_oe ? ANA_B_I : 8'h00;

    // Shaped pixel clock: toggles every div+1 cycles, held low while gated. [RL7]
    if (s_q.div_cnt >= s_q.div) begin
      s_d.div_cnt = 4'h0;
      s_d.pclk = !s_q.pclk;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 4'h1;
    end
    if (s_q.gate_en && !SYNC_MIX_I[7]) begin
      s_d.pclk = 1'b0; // [RL7]
    end
    s_d.pclk_oe = s_q.pclk_out_en; // [RL7]

    if (SYS_RST_I) begin
      s_d = '0;
      s_d.scan = `DPM_RST_SCAN;
      s_d.fmt = `DPM_RST_FMT;
      s_d.doe = `DPM_RST_DOE;
      s_d.div = `DPM_RST_DIV;
      s_d.dly_sel = `DPM_RST_DLY;
      s_d.apb = dpm_pkg::APB_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Half-cycle delay on the top pins.

  // Delaying after the output register keeps the edge where it would land if the
  // delay sat before the selector, and it is only enabled while syncs are routed.
  dpm_half_delay #(
    .WIDTH(5)
  ) u_dly (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .sig_i(s_q.dis_d[23:19]),
    .sel_i(s_q.dly_use),
    .sig_o(top_dly)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign PREADY_O = s_q.pready;
  assign PSLVERR_O = s_q.pslverr;
  assign PRDATA_O = s_q.prdata;
  assign PIX_READY_O = fifo_ready;
  assign DIS_D_O = {top_dly, s_q.dis_d[18:0]};
  assign DIS_D_OE_O = s_q.dis_oe;
  assign DIS_PCLK_O = s_q.pclk;
  assign DIS_PCLK_OE_O = s_q.pclk_oe;
  assign ANA_R_O = s_q.ana_r;
  assign ANA_G_O = s_q.ana_g;
  assign ANA_B_O = s_q.ana_b;
  assign ANA_OE_O = s_q.ana_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  single_top_route_a: assert property ( // [RL1]
    ($past(s_q.scan) == `DPM_SCAN_SINGLE) && !$past(sync_on_top(s_q.scan, s_q.fmt, s_q.twin))
    |-> (s_q.dis_d[23:19] == $past(s_q.pix[23:19])) && (s_q.dly_use == 5'h00))
    else $error("Top pins do not carry pixel data.");
  dual_seg_map_a: assert property ( // [RL2]
    $past(s_q.scan) == `DPM_SCAN_DUAL |-> s_q.dis_d[15:0] == $past(s_q.pix[15:0]))
    else $error("Dual scan segment data misplaced.");
  dual_sync_zero_a: assert property ( // [RL3]
    $past(s_q.scan) == `DPM_SCAN_DUAL
    |-> s_q.dis_d[18:16] == 3'h0 && s_q.dis_d[23:19] == $past(SYNC_MIX_I[7:3]))
    else $error("Dual scan upper pins wrong.");
  zigzag_map_a: assert property ( // [RL4]
    $past(s_q.scan) == `DPM_SCAN_ZIGZAG
    |-> s_q.dis_d[18:8] == 11'h000 && s_q.dis_d[7:0] == $past(s_q.pix[7:0]))
    else $error("Zigzag pin map wrong.");
  sync_order_a: assert property ( // [RL12]
    $past(sync_on_top(s_q.scan, s_q.fmt, s_q.twin)) && $past(s_q.scan) != `DPM_SCAN_ILLEGAL
    |-> s_q.dis_d[23:19] == $past(SYNC_MIX_I[7:3]))
    else $error("Sync outputs in wrong pin order.");
  pin_enable_a: assert property ( // [RL6]
    (DIS_D_OE_O & ~$past(s_q.doe)) == 24'h00_0000)
    else $error("Pin driven with its enable cleared.");
  illegal_scan_a: assert property ( // [RL10]
    s_q.scan == `DPM_SCAN_ILLEGAL |=> DIS_D_OE_O == 24'h00_0000)
    else $error("Illegal scan code drives pins.");
  analog_drive_a: assert property ( // [RL8]
    ANA_OE_O == $past(s_q.dac_oe && analog_on(s_q.scan, s_q.fmt, s_q.twin)))
    else $error("Analog enable disagrees with mode.");
  dac_off_a: assert property ( // [RL9]
    !s_q.dac_oe |=> !ANA_OE_O)
    else $error("Analog pins driven with converter disabled.");
  pclk_gate_a: assert property ( // [RL7]
    s_q.gate_en && !SYNC_MIX_I[7] |=> !DIS_PCLK_O && (DIS_PCLK_OE_O == $past(s_q.pclk_out_en)))
    else $error("Pixel clock not held by gate.");
  apb_answer_a: assert property (
    s_q.apb == dpm_pkg::APB_IDLE && PSEL_I && PENABLE_I |=> PREADY_O ##1 !PREADY_O)
    else $error("APB answer not one cycle.");

  dual_scan_c: cover property (s_q.scan == `DPM_SCAN_DUAL && fifo_pop);
  analog_twin_c: cover property (ANA_OE_O && s_q.twin);
  fifo_full_c: cover property (PIX_VALID_I && !PIX_READY_O);

endmodule

// ### sim/dpm_panel.sv
// Display panel model that sees the connector pins as resolved wires.
`timescale 1ns/1ns
module dpm_panel (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Connector pins as driven by the controller.
  input wire logic [23:0] d_i,
  input wire logic [23:0] oe_i,
  input wire logic pclk_i,
  input wire logic pclk_oe_i,
  // Levels that the panel sees, and its count of clock rises.
  output logic [23:0] pin_o,
  output logic [15:0] rise_o
);
  logic [23:0] last_q;
  logic pclk_q;
  ////////////////////////////////////////////////////////////////////////////////
  // A released pin has no pull, so it shows a level that flips every cycle.
  // That way a stale value can never pass for a driven one.
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin_o[i] = oe_i[i] ? d_i[i] : ~last_q[i];
    end
  end
  // Reset gives the floating pins a known start, or they would stay unknown for good.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= 24'h00_0000;
      pclk_q <= 1'b0;
      rise_o <= 16'h0000;
    end else begin
      last_q <= pin_o;
      pclk_q <= pclk_oe_i & pclk_i;
      if (pclk_oe_i & pclk_i & ~pclk_q) begin
        rise_o <= rise_o + 16'h0001;
      end
    end
  end
endmodule

// ### sim/tb.sv
// Self-checking testbench for the display pin multiplexer.
`timescale 1ns/1ns
`include "dpm_regs.svh"
module tb;
  logic clk, rst, psel, pen, pwr, pix_valid, pix_stall, pready, pslverr, pix_ready;
  logic pclk, pclk_oe, ana_oe, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] pix_data, dis_d, dis_oe, pin;
  logic [7:0] sync, ana_r, ana_g, ana_b;
  logic [15:0] rises;
  int err_total = 0;
  int n_checks = 0;
  localparam logic [23:0] PX = 24'h5A_C3E1;
  localparam logic [11:0] MODES [10] = '{12'h080, 12'h090, 12'h190, 12'h150, 12'h0A0,
    12'h092, 12'h152, 12'h083, 12'h193, 12'h081};

  dpm_top dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PRDATA_O(prdata), .PIX_VALID_I(pix_valid), .PIX_DATA_I(pix_data),
    .PIX_READY_O(pix_ready), .PIX_STALL_I(pix_stall), .SYNC_MIX_I(sync), .ANA_R_I(8'h3C),
    .ANA_G_I(8'hC3), .ANA_B_I(8'h5A), .DIS_D_O(dis_d), .DIS_D_OE_O(dis_oe),
    .DIS_PCLK_O(pclk), .DIS_PCLK_OE_O(pclk_oe), .ANA_R_O(ana_r), .ANA_G_O(ana_g),
    .ANA_B_O(ana_b), .ANA_OE_O(ana_oe));
  dpm_panel panel (.clk_i(clk), .rst_i(rst), .d_i(dis_d), .oe_i(dis_oe), .pclk_i(pclk),
    .pclk_oe_i(pclk_oe), .pin_o(pin), .rise_o(rises));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic give_up(input int i);
    if (i >= 20) begin
      chk(32'h0000_0000, 32'h0000_0001);
      end_sim();
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        break;
      end
    end
    give_up(i);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic push(input logic [23:0] w);
    int i;
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_data <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pix_ready === 1'b1) begin
        break;
      end
    end
    give_up(i);
    pix_valid <= 1'b0;
  endtask
  function automatic logic [23:0] pins(input logic [11:0] m);
    case (m[1:0])
      `DPM_SCAN_SINGLE: pins = (m[7:4] == `DPM_FMT_24BIT || (m[7:4] == `DPM_FMT_ANALOG && m[8]))
        ? PX : {sync[7:3], PX[18:0]};
      `DPM_SCAN_DUAL: pins = {sync[7:3], 3'h0, PX[15:0]};
      `DPM_SCAN_ZIGZAG: pins = {sync[7:3], 11'h000, PX[7:0]};
      default: pins = 24'h00_0000;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset();
    apb(1'b0, `DPM_ADDR_CFG, 32'h0000_0000);
    chk(rd, 32'h0000_0080);
    apb(1'b0, `DPM_ADDR_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(rerr, 1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(rerr, 1'b1);
    apb(1'b1, `DPM_ADDR_STAT, 32'h0000_00FF);
    chk(rerr, 1'b1);
    chk({dis_oe, pclk_oe, ana_oe}, 26'h000_0000);
  endtask
  task automatic sc_modes();
    logic ana_exp;
    apb(1'b1, `DPM_ADDR_DOE, 32'h00FF_FFFF);
    apb(1'b1, `DPM_ADDR_CTRL, 32'h0000_0002);
    push(PX);
    foreach (MODES[k]) begin
      apb(1'b1, `DPM_ADDR_CFG, {20'h0_0000, MODES[k]});
      settle(3);
      ana_exp = (MODES[k][7:0] == 8'h90) || (MODES[k][8] && MODES[k][7:4] >= 4'h5
        && MODES[k][7:4] <= 4'h8);
      chk(dis_d, pins(MODES[k]));
      chk(dis_oe, (MODES[k][1:0] == 2'h1) ? 24'h00_0000 : 24'hFF_FFFF);
      chk({ana_oe, ana_r, ana_g, ana_b}, ana_exp ? 25'h13C_C35A : 25'h000_0000);
      apb(1'b0, `DPM_ADDR_STAT, 32'h0000_0000);
      chk(rd[3:2], {MODES[k][7:4] >= 4'hA, MODES[k][1:0] == 2'h1});
    end
    apb(1'b1, `DPM_ADDR_CTRL, 32'h0000_0000);
    settle(3);
    chk(ana_oe, 1'b0);
  endtask
  task automatic sc_oe();
    logic [23:0] p0;
    apb(1'b1, `DPM_ADDR_CFG, 32'h0000_0080);
    apb(1'b1, `DPM_ADDR_DOE, 32'h00F0_0F0F);
    settle(3);
    chk(dis_oe, 24'hF0_0F0F);
    chk(pin & 24'hF0_0F0F, PX & 24'hF0_0F0F);
    // A released pin floats and flips every cycle, so it cannot carry pixel data.
    p0 = pin;
    settle(1);
    chk((pin ^ p0) & 24'h0F_F0F0, 24'h0F_F0F0);
  endtask
  task automatic sc_pclk();
    logic [15:0] r0;
    apb(1'b1, `DPM_ADDR_CTRL, 32'h0000_0011);
    settle(4);
    r0 = rises;
    settle(40);
    chk(pclk_oe, 1'b1);
    chk((rises - r0) >= 16'd9 && (rises - r0) <= 16'd11, 1'b1);
    @(posedge clk);
    sync <= 8'h25;
    apb(1'b1, `DPM_ADDR_CTRL, 32'h0000_0015);
    settle(4);
    r0 = rises;
    settle(20);
    chk(rises, r0);
    @(posedge clk);
    sync <= 8'hA5;
    apb(1'b1, `DPM_ADDR_CTRL, 32'h0000_0000);
    settle(3);
    chk(pclk_oe, 1'b0);
  endtask
  task automatic sc_delay();
    apb(1'b1, `DPM_ADDR_CFG, 32'h0000_0002);
    apb(1'b1, `DPM_ADDR_CTRL, 32'h0000_0100);
    settle(3);
    chk(dis_d[23:19], 5'b10100);
    @(posedge clk);
    sync <= 8'h5A;
    // Before the falling edge only pin 19 still shows the old sync level.
    settle(1);
    chk(dis_d[23:19], 5'b01010);
    #5;
    chk(dis_d[23:19], 5'b01011);
    apb(1'b1, `DPM_ADDR_CTRL, 32'h0000_0000);
    @(posedge clk);
    sync <= 8'hA5;
  endtask
  task automatic sc_fifo();
    logic [23:0] w [4] = '{24'h11_2233, 24'h44_5566, 24'h77_8899, 24'hAA_BBCC};
    int idx;
    apb(1'b1, `DPM_ADDR_DOE, 32'h00FF_FFFF);
    @(posedge clk);
    pix_stall <= 1'b1;
    foreach (w[k]) begin
      push(w[k]);
    end
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_data <= 24'hFF_FFFF;
    settle(2);
    chk(pix_ready, 1'b0);
    @(posedge clk);
    pix_valid <= 1'b0;
    pix_stall <= 1'b0;
    idx = 0;
    repeat (10) begin
      settle(1);
      if (idx < 4 && dis_d === w[idx]) begin
        idx++;
      end
    end
    chk(idx, 4);
    chk(pix_ready, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pix_valid = 1'b0;
    pix_stall = 1'b0;
    pix_data = 24'h00_0000;
    sync = 8'hA5;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    sc_reset();
    sc_modes();
    sc_oe();
    sc_pclk();
    sc_fifo();
    sc_delay();
    end_sim();
  end
endmodule
